//--- verilog/temp_limit_status_regs.sv
// Purpose: register side of the temperature sensor: critical floor limit,
//   measured temperature, limit status, bus error log and pending interrupt flag
// Assumes: the bus protocol engine, the converter and the other limit registers
//   run on clk and hand over single-cycle strobes; no synchroniser is needed
// Notes: reads answer one cycle after the read strobe on rdData
`default_nettype none
`timescale 1ns/1ps
module temp_limit_status_regs
	import temp_limit_pkg::*;
#(
	parameter int TW = TEMP_W
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// register access from the bus protocol engine
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] wrData,
	output logic [DATA_W-1:0] rdData,
	output logic rdValid,
	// conversion result
	input wire logic convDone,
	input wire logic [TW-1:0] convTemp,
	// limits held outside this block
	input wire logic [TW-1:0] ceilingLimit,
	input wire logic [TW-1:0] floorLimit,
	input wire logic [TW-1:0] critCeilingLimit,
	// bus protocol status
	input wire logic busReset,
	input wire logic pecEnable,
	input wire logic pecError,
	input wire logic parityDisable,
	input wire logic parityError,
	input wire logic twoWireMode,
	input wire logic commonCmd,
	input wire logic errIrqEnable,
	input wire logic ibiDone,
	// to the limit registers and the in-band interrupt engine
	output logic [TW-1:0] critFloorLimit,
	output logic errLogEnable,
	output logic ibiRequest
);

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [DATA_W-1:0] critFloorLo;
	logic [DATA_W-1:0] critFloorHi;
	logic [TW-1:0] measuredTemp;
	logic errLogEn;
	logic [FLAG_N-1:0] flagIrqEn;
	logic pecFlag;
	logic parFlag;
	logic pendingFlag;
	logic [DATA_W-1:0] readByte;
	logic readStrobe;

	logic [DATA_W-1:0] next_critFloorLo;
	logic [DATA_W-1:0] next_critFloorHi;
	logic [TW-1:0] next_measuredTemp;
	logic next_errLogEn;
	logic [FLAG_N-1:0] next_flagIrqEn;
	logic next_pecFlag;
	logic next_parFlag;
	logic next_pendingFlag;
	logic [DATA_W-1:0] next_readByte;
	logic next_readStrobe;

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic wrIfCfg;
	logic wrTsClear;
	logic wrIrqCfg;
	logic globalClear;
	logic [FLAG_N-1:0] flagClear;
	logic [FLAG_N-1:0] flags;
	logic [FLAG_N-1:0] trips;
	logic [TW-1:0] limits [FLAG_N];
	logic pecLog;
	logic parLog;
	logic errClear;
	logic newEvent;

	always_comb begin
		wrIfCfg = regWrite && (regAddr == ADDR_IF_CFG);
		wrTsClear = regWrite && (regAddr == ADDR_TS_CLEAR);
		wrIrqCfg = regWrite && (regAddr == ADDR_IRQ_CFG);
		// the clear command bits never store; they act in the write cycle
		globalClear = wrIrqCfg && wrData[BIT_GLOBAL_CLEAR];
		flagClear = {FLAG_N{globalClear}};
		if (wrTsClear) begin
			flagClear = flagClear | wrData[FLAG_N-1:0];
		end
		limits[BIT_CRIT_LOW] = {critFloorHi, critFloorLo};
		limits[BIT_CRIT_HIGH] = critCeilingLimit;
		limits[BIT_LOW] = floorLimit;
		limits[BIT_HIGH] = ceilingLimit;
	end

	////////////////////////////////////////////////////////////////////////////
	// limit status flags, compared against the conversion as it lands
	genvar gi;
	generate
		for (gi = 0; gi < FLAG_N; gi++) begin : gFlag
			limit_flag #(
				.BELOW(BELOW_MASK[gi]),
				.WIDTH(TW)
			) uFlag (
				.clk(clk),
				.resetn(resetn),
				.ce(ce),
				.update(convDone),
				.temp(convTemp),
				.limit(limits[gi]),
				.clear(flagClear[gi]),
				.flag(flags[gi]),
				.trip(trips[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// error logging and the pending interrupt
	always_comb begin
		pecLog = pecError && errLogEn && pecEnable;
		parLog = parityError && ((errLogEn && !parityDisable) || (twoWireMode && commonCmd));
		errClear = globalClear || busReset;

		next_pecFlag = pecFlag;
		if (errClear) begin
			next_pecFlag = 1'b0;
		end
		if (pecLog) begin
			next_pecFlag = 1'b1;
		end

		next_parFlag = parFlag;
		if (errClear) begin
			next_parFlag = 1'b0;
		end
		if (parLog) begin
			next_parFlag = 1'b1;
		end

		// only fresh events raise a request, so a global clear drops old ones for good
		newEvent = errIrqEnable && (|(trips & flagIrqEn) || pecLog || parLog);
		next_pendingFlag = pendingFlag;
		if (globalClear || ibiDone) begin
			next_pendingFlag = 1'b0;
		end
		if (newEvent) begin
			next_pendingFlag = 1'b1;
		end
	end

	// error and pending flags hold while ce is low; strobes arriving then are dropped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pecFlag <= 1'b0;
			parFlag <= 1'b0;
			pendingFlag <= 1'b0;
		end else if (ce) begin
			pecFlag <= next_pecFlag;
			parFlag <= next_parFlag;
			pendingFlag <= next_pendingFlag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// writable registers and the conversion latch
	always_comb begin
		next_critFloorLo = critFloorLo;
		next_critFloorHi = critFloorHi;
		next_errLogEn = errLogEn;
		next_flagIrqEn = flagIrqEn;
		next_measuredTemp = measuredTemp;
		if (regWrite && (regAddr == ADDR_CRIT_FLOOR_LO)) begin
			next_critFloorLo = wrData;
		end
		if (regWrite && (regAddr == ADDR_CRIT_FLOOR_HI)) begin
			next_critFloorHi = wrData;
		end
		if (wrIfCfg) begin
			next_errLogEn = wrData[BIT_ERR_LOG_EN];
		end
		if (wrIrqCfg) begin
			// the error interrupt enable is owned by the protocol engine, not writable here
			next_flagIrqEn = wrData[FLAG_N-1:0];
		end
		if (convDone) begin
			next_measuredTemp = convTemp;
		end
	end

	// the floor bytes load one at a time; a conversion between the two writes sees a mixed pair
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			critFloorLo <= BYTE_RST;
			critFloorHi <= BYTE_RST;
			measuredTemp <= TEMP_RST;
			errLogEn <= 1'b0;
			flagIrqEn <= FLAGS_RST;
		end else if (ce) begin
			critFloorLo <= next_critFloorLo;
			critFloorHi <= next_critFloorHi;
			measuredTemp <= next_measuredTemp;
			errLogEn <= next_errLogEn;
			flagIrqEn <= next_flagIrqEn;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; every unused or unmapped bit reads zero
	always_comb begin
		next_readByte = BYTE_RST;
		next_readStrobe = regRead;
		if (regRead) begin
			case (regAddr)
				ADDR_CRIT_FLOOR_LO: begin
					next_readByte = critFloorLo;
				end
				ADDR_CRIT_FLOOR_HI: begin
					next_readByte = critFloorHi;
				end
				ADDR_DEV_STATUS: begin
					next_readByte[BIT_IBI_PENDING] = pendingFlag;
				end
				ADDR_TEMP_LO: begin
					next_readByte = measuredTemp[DATA_W-1:0];
				end
				ADDR_TEMP_HI: begin
					next_readByte = measuredTemp[TW-1:DATA_W];
				end
				ADDR_LIMIT_STATUS: begin
					next_readByte[FLAG_N-1:0] = flags;
				end
				ADDR_ERR_STATUS: begin
					next_readByte[BIT_PEC] = pecFlag;
					next_readByte[BIT_PAR] = parFlag;
				end
				ADDR_IF_CFG: begin
					next_readByte[BIT_ERR_LOG_EN] = errLogEn;
				end
				ADDR_IRQ_CFG: begin
					next_readByte[BIT_ERR_IRQ_EN] = errIrqEnable;
					next_readByte[FLAG_N-1:0] = flagIrqEn;
				end
				default: begin
					// clear-command registers and unmapped indices read zero
					next_readByte = BYTE_RST;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read answer register
	// the answer byte falls back to zero between reads so the engine never forwards a stale byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readByte <= BYTE_RST;
			readStrobe <= 1'b0;
		end else if (ce) begin
			readByte <= next_readByte;
			readStrobe <= next_readStrobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdData = readByte;
	assign rdValid = readStrobe;
	assign critFloorLimit = {critFloorHi, critFloorLo};
	assign errLogEnable = errLogEn;
	assign ibiRequest = pendingFlag;

endmodule : temp_limit_status_regs
`default_nettype wire

//--- verilog/temp_limit_pkg.sv
// Purpose: shared constants for the temperature limit and status register block
// Assumes: register indices are the byte addresses seen by the bus protocol engine
// Notes: all fields are 8-bit registers; temperature words are 16-bit signed
`default_nettype none
package temp_limit_pkg;
	localparam int DATA_W = 8;
	localparam int TEMP_W = 16;
	localparam int ADDR_W = 8;
	localparam int FLAG_N = 4;

	// register indices
	localparam logic [ADDR_W-1:0] ADDR_IF_CFG = 8'h12;
	localparam logic [ADDR_W-1:0] ADDR_TS_CLEAR = 8'h13;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CFG = 8'h1B;
	localparam logic [ADDR_W-1:0] ADDR_CRIT_FLOOR_LO = 8'h22;
	localparam logic [ADDR_W-1:0] ADDR_CRIT_FLOOR_HI = 8'h23;
	localparam logic [ADDR_W-1:0] ADDR_DEV_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_TEMP_LO = 8'h31;
	localparam logic [ADDR_W-1:0] ADDR_TEMP_HI = 8'h32;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_STATUS = 8'h33;
	localparam logic [ADDR_W-1:0] ADDR_ERR_STATUS = 8'h34;

	// field positions
	localparam int BIT_IBI_PENDING = 7;
	localparam int BIT_CRIT_LOW = 3;
	localparam int BIT_CRIT_HIGH = 2;
	localparam int BIT_LOW = 1;
	localparam int BIT_HIGH = 0;
	localparam int BIT_PEC = 1;
	localparam int BIT_PAR = 0;
	localparam int BIT_ERR_LOG_EN = 5;
	localparam int BIT_GLOBAL_CLEAR = 7;
	localparam int BIT_ERR_IRQ_EN = 4;

	// reset values
	localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
	localparam logic [TEMP_W-1:0] TEMP_RST = 16'h0000;
	localparam logic [FLAG_N-1:0] FLAGS_RST = 4'h0;

	// flags that trip when temperature is below their limit; the rest trip above
	localparam logic [FLAG_N-1:0] BELOW_MASK = 4'hA;
endpackage : temp_limit_pkg
`default_nettype wire

//--- verilog/limit_flag.sv
// Purpose: one sticky limit-compare status flag
// Assumes: temperature and limit share the same signed 16-bit format
// Notes: a new trip in the cycle of a clear wins over the clear
`default_nettype none
`timescale 1ns/1ps
module limit_flag
	import temp_limit_pkg::*;
#(
	parameter bit BELOW = 1'b0,
	parameter int WIDTH = TEMP_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// compare inputs
	input wire logic update,
	input wire logic [WIDTH-1:0] temp,
	input wire logic [WIDTH-1:0] limit,
	input wire logic clear,
	// status
	output logic flag,
	output logic trip
);
	logic next_flag;
	logic beyond;

	always_comb begin
		if (BELOW) begin
			beyond = $signed(temp) < $signed(limit);
		end else begin
			beyond = $signed(temp) > $signed(limit);
		end
		trip = update && beyond;
		next_flag = flag;
		if (clear) begin
			next_flag = 1'b0;
		end
		if (trip) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag <= 1'b0;
		end else if (ce) begin
			flag <= next_flag;
		end
	end
endmodule : limit_flag
`default_nettype wire

//--- dv/temp_limit_sva.sv
// Purpose: port checks for the temperature limit register block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound from the testbench top file
`default_nettype none
`timescale 1ns/1ps
module temp_limit_sva
	import temp_limit_pkg::*;
#(
	parameter int TW = TEMP_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// register access
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic rdValid,
	// watched outputs and the ibiDone input
	input wire logic ibiDone,
	input wire logic [TW-1:0] critFloorLimit,
	input wire logic errLogEnable,
	input wire logic ibiRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	a_read_answered: assert property (ce && regRead |=> rdValid)
		else $error("read not answered");
	a_idle_reads_zero: assert property (ce && !regRead |=> !rdValid && rdData == 8'h00)
		else $error("data without read");
	a_floor_lo_write: assert property (ce && regWrite && regAddr == ADDR_CRIT_FLOOR_LO
		|=> critFloorLimit[7:0] == $past(wrData)) else $error("floor low byte lost");
	a_floor_hi_write: assert property (ce && regWrite && regAddr == ADDR_CRIT_FLOOR_HI
		|=> critFloorLimit[TW-1:8] == $past(wrData)) else $error("floor high byte lost");
	a_log_enable_write: assert property (ce && regWrite && regAddr == ADDR_IF_CFG
		|=> errLogEnable == $past(wrData[BIT_ERR_LOG_EN])) else $error("log enable lost");
	a_status_read: assert property (ce && regRead && regAddr == ADDR_DEV_STATUS
		|=> rdData == {$past(ibiRequest), 7'h00}) else $error("device status wrong");
	a_limit_reserved: assert property (ce && regRead && regAddr == ADDR_LIMIT_STATUS
		|=> rdData[7:4] == 4'h0) else $error("limit status reserved set");
	a_err_reserved: assert property (ce && regRead && regAddr == ADDR_ERR_STATUS
		|=> rdData[7:2] == 6'h00) else $error("error status reserved set");
	// pending may only drop on delivery or a global clear
	a_pending_holds: assert property (ce && ibiRequest && !ibiDone
		&& !(regWrite && regAddr == ADDR_IRQ_CFG && wrData[BIT_GLOBAL_CLEAR]) |=> ibiRequest)
		else $error("pending dropped");
endmodule : temp_limit_sva
`default_nettype wire

//--- dv/bus_host_model.sv
// Purpose: host side of the register access path
// Assumes: strobes one cycle, driven at the falling edge
// Notes: idle address and data show the inverse of the last value, not a stale copy
`default_nettype none
`timescale 1ns/1ps
module bus_host_model
	import temp_limit_pkg::*;
(
	// clock
	input wire logic clk,
	// requests
	output logic regWrite,
	output logic regRead,
	output logic [ADDR_W-1:0] regAddr,
	output logic [DATA_W-1:0] wrData,
	// answer
	input wire logic [DATA_W-1:0] rdData,
	input wire logic rdValid
);
	initial begin
		{regWrite, regRead, regAddr, wrData} = '0;
	end
	////////////////////////////////////////////////////////////////
	// callers keep reserved bits at zero
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		regAddr = a;
		wrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		regAddr = ~a;
		wrData = ~d;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		d = rdValid ? rdData : 8'hXX;
		regRead = 1'b0;
		regAddr = ~a;
	endtask : rd
endmodule : bus_host_model
`default_nettype wire

//--- dv/temp_limit_status_regs_test.sv
// Purpose: self-checking bench for the temperature limit register block
// Assumes: ce held high; limits outside the block driven here
// Notes: inputs change at the falling edge only
`default_nettype none
`timescale 1ns/1ps
module temp_limit_status_regs_test
	import temp_limit_pkg::*;
;
	logic clk;
	logic resetn;
	logic convDone, busReset, pecEnable, pecError, parityDisable, parityError;
	logic twoWireMode, commonCmd, errIrqEnable, ibiDone;
	logic regWrite, regRead, rdValid, errLogEnable, ibiRequest;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] wrData, rdData, rb;
	logic [TEMP_W-1:0] convTemp, ceilingLimit, floorLimit, critCeilingLimit, critFloorLimit;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	localparam logic [ADDR_W-1:0] ADDRS [8] = '{ADDR_CRIT_FLOOR_LO, ADDR_CRIT_FLOOR_HI, ADDR_DEV_STATUS,
		ADDR_TEMP_LO, ADDR_TEMP_HI, ADDR_LIMIT_STATUS, ADDR_ERR_STATUS, 8'h40};
	temp_limit_status_regs #(.TW(TEMP_W)) u_dut(.clk(clk), .resetn(resetn), .ce(1'b1),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .wrData(wrData), .rdData(rdData),
		.rdValid(rdValid), .convDone(convDone), .convTemp(convTemp), .ceilingLimit(ceilingLimit),
		.floorLimit(floorLimit), .critCeilingLimit(critCeilingLimit), .busReset(busReset),
		.pecEnable(pecEnable), .pecError(pecError), .parityDisable(parityDisable),
		.parityError(parityError), .twoWireMode(twoWireMode), .commonCmd(commonCmd),
		.errIrqEnable(errIrqEnable), .ibiDone(ibiDone), .critFloorLimit(critFloorLimit),
		.errLogEnable(errLogEnable), .ibiRequest(ibiRequest));
	bus_host_model u_host(.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.wrData(wrData), .rdData(rdData), .rdValid(rdValid));
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [TEMP_W-1:0] seen, input logic [TEMP_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		u_host.rd(a, rb);
		chk({8'h00, rb}, {8'h00, exp});
	endtask : rdChk
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// a hang costs a mismatch; the sequence needs under a hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		resetn = 1'b0;
		{convDone, busReset, pecEnable, pecError, parityDisable, parityError} = '0;
		{twoWireMode, commonCmd, errIrqEnable, ibiDone, convTemp} = '0;
		ceilingLimit = 16'h0055;
		critCeilingLimit = 16'h0064;
		floorLimit = 16'hFFCE;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		foreach (ADDRS[i]) rdChk(ADDRS[i], 8'h00);
		u_host.wr(ADDR_TEMP_LO, 8'h55);
		rdChk(ADDR_TEMP_LO, 8'h00);
		u_host.wr(ADDR_CRIT_FLOOR_LO, 8'h9C);
		u_host.wr(ADDR_CRIT_FLOOR_HI, 8'hFF);
		rdChk(ADDR_CRIT_FLOOR_HI, 8'hFF);
		chk(critFloorLimit, 16'hFF9C);
		errIrqEnable = 1'b1;
		u_host.wr(ADDR_IRQ_CFG, 8'h0F);
		convTemp = 16'hFF88;
		pulse(convDone);
		chk(ibiRequest, 16'h0001);
		rdChk(ADDR_DEV_STATUS, 8'h80);
		rdChk(ADDR_TEMP_HI, 8'hFF);
		rdChk(ADDR_TEMP_LO, 8'h88);
		rdChk(ADDR_LIMIT_STATUS, 8'h0A);
		pulse(ibiDone);
		chk(ibiRequest, 16'h0000);
		u_host.wr(ADDR_TS_CLEAR, 8'h08);
		convTemp = 16'h0000;
		pulse(convDone);
		rdChk(ADDR_LIMIT_STATUS, 8'h02);
		rdChk(ADDR_TS_CLEAR, 8'h00);
		errIrqEnable = 1'b0;
		convTemp = 16'h0078;
		pulse(convDone);
		chk(ibiRequest, 16'h0000);
		rdChk(ADDR_LIMIT_STATUS, 8'h07);
		errIrqEnable = 1'b1;
		pecEnable = 1'b1;
		pulse(pecError);
		pulse(parityError);
		rdChk(ADDR_ERR_STATUS, 8'h00);
		u_host.wr(ADDR_IF_CFG, 8'h20);
		chk(errLogEnable, 16'h0001);
		pulse(pecError);
		pulse(parityError);
		rdChk(ADDR_ERR_STATUS, 8'h03);
		pulse(busReset);
		rdChk(ADDR_ERR_STATUS, 8'h00);
		parityDisable = 1'b1;
		twoWireMode = 1'b1;
		pulse(parityError);
		rdChk(ADDR_ERR_STATUS, 8'h00);
		u_host.wr(ADDR_IF_CFG, 8'h00);
		commonCmd = 1'b1;
		pulse(parityError);
		pulse(pecError);
		rdChk(ADDR_ERR_STATUS, 8'h01);
		chk(ibiRequest, 16'h0001);
		u_host.wr(ADDR_IRQ_CFG, 8'h80);
		chk(ibiRequest, 16'h0000);
		rdChk(ADDR_LIMIT_STATUS, 8'h00);
		rdChk(ADDR_ERR_STATUS, 8'h00);
		conclude();
	end
endmodule : temp_limit_status_regs_test
bind temp_limit_status_regs temp_limit_sva #(.TW(TW)) u_sva(.clk(clk), .resetn(resetn), .ce(ce),
	.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .wrData(wrData), .rdData(rdData),
	.rdValid(rdValid), .ibiDone(ibiDone), .critFloorLimit(critFloorLimit),
	.errLogEnable(errLogEnable), .ibiRequest(ibiRequest));
`default_nettype wire
